/* File: hw/ddrbs_pkg.sv */
/*
 package for the ddr2 bank state tracker: command codes, bank states,
 timing counts, command carrier struct.
 assumes one 25 MHz clock; timing counts are cycle counts of that clock.
*/
package ddrbs_pkg;
   localparam int unsigned NUM_BANKS   = 8;
   localparam int unsigned BA_W        = 3;
   localparam int unsigned CNT_W       = 8;
   localparam int unsigned ADDR_W      = 14;
   localparam int unsigned AP_BIT      = 10;
   localparam int unsigned BURST_BL4   = 4;
   localparam int unsigned BURST_BL8   = 8;
   localparam int unsigned BEAT_W      = 4;
   localparam int unsigned DATA_RATE   = 2;

   typedef logic [CNT_W-1:0] ddrbs_cnt_t;

   // default timings in cycles of the 40 ns clock
   localparam ddrbs_cnt_t T_RP_DEF   = 8'h02;
   localparam ddrbs_cnt_t T_RCD_DEF  = 8'h02;
   localparam ddrbs_cnt_t T_WR_DEF   = 8'h02;
   localparam ddrbs_cnt_t T_RC_DEF   = 8'h05;
   localparam ddrbs_cnt_t T_MRD_DEF  = 8'h02;
   localparam ddrbs_cnt_t CNT_ONE    = 8'h01;
   localparam ddrbs_cnt_t CNT_ZERO   = 8'h00;

   typedef enum logic [2:0] {
      CMD_DESEL, CMD_NOP, CMD_READ, CMD_WRITE, CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS
   } ddrbs_cmd_e;

   typedef enum logic [3:0] {
      BS_IDLE, BS_ACTIVATING, BS_ACTIVE, BS_READ, BS_WRITE, BS_READ_AP, BS_WRITE_AP,
      BS_WRREC, BS_WRREC_AP, BS_PRECHARGING, BS_REFRESHING, BS_MRS
   } ddrbs_state_e;

   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BA_W-1:0]   ba;
      logic [ADDR_W-1:0] addr;
   } ddrbs_pins_s;

   typedef struct packed {
      ddrbs_cnt_t t_rp;
      ddrbs_cnt_t t_rcd;
      ddrbs_cnt_t t_wr;
      ddrbs_cnt_t t_rc;
      ddrbs_cnt_t t_mrd;
   } ddrbs_timing_s;
endpackage

/* File: hw/ddrbs_bank.sv */
/*
 one bank's state machine and timing counter.
 assumes decoded command and global idle/legality come from the top.
*/
`timescale 1ns/1ps
module ddrbs_bank (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // command to this bank
   input  wire logic                  cmd_hit,
   input  ddrbs_pkg::ddrbs_cmd_e      cmd,
   input  wire logic                  auto_pre,
   input  wire logic                  cmd_legal,
   input  wire logic                  all_cmd,
   // configuration
   input  ddrbs_pkg::ddrbs_timing_s   timing,
   input  ddrbs_pkg::ddrbs_cnt_t      burst_cycles,
   // status
   output ddrbs_pkg::ddrbs_state_e    state,
   output logic                       cnt_zero
);
   ddrbs_pkg::ddrbs_state_e state_q;
   ddrbs_pkg::ddrbs_cnt_t   cnt_q;
   logic                    done;
   logic                    starts;

   assign state    = state_q;
   assign done     = (cnt_q <= ddrbs_pkg::CNT_ONE);
   assign cnt_zero = (cnt_q == ddrbs_pkg::CNT_ZERO);
   // only commands that open a timed phase reload; nop, deselect and a repeated
   // precharge must let the running timer go on, or a nop to this bank would stall it
   assign starts = cmd_hit && cmd_legal &&
      ((cmd inside {ddrbs_pkg::CMD_ACT, ddrbs_pkg::CMD_READ, ddrbs_pkg::CMD_WRITE}) ||
       ((cmd == ddrbs_pkg::CMD_PRE) && (state_q != ddrbs_pkg::BS_PRECHARGING)));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ddrbs_pkg::BS_IDLE;
         cnt_q   <= ddrbs_pkg::CNT_ZERO;
      end else if (all_cmd && cmd_legal) begin
         // refresh and mode set act on every bank at once
         state_q <= (cmd == ddrbs_pkg::CMD_REF) ? ddrbs_pkg::BS_REFRESHING : ddrbs_pkg::BS_MRS;
         cnt_q   <= (cmd == ddrbs_pkg::CMD_REF) ? timing.t_rc : timing.t_mrd;
      end else if (starts) begin
         case (cmd)
            ddrbs_pkg::CMD_ACT: begin
               state_q <= ddrbs_pkg::BS_ACTIVATING;
               cnt_q   <= timing.t_rcd;
            end
            ddrbs_pkg::CMD_READ: begin
               state_q <= auto_pre ? ddrbs_pkg::BS_READ_AP : ddrbs_pkg::BS_READ;
               cnt_q   <= burst_cycles;
            end
            ddrbs_pkg::CMD_WRITE: begin
               state_q <= auto_pre ? ddrbs_pkg::BS_WRITE_AP : ddrbs_pkg::BS_WRITE;
               cnt_q   <= burst_cycles;
            end
            ddrbs_pkg::CMD_PRE: begin
               // a further precharge while precharging leaves the timer alone
               if (state_q != ddrbs_pkg::BS_PRECHARGING) begin
                  state_q <= (state_q == ddrbs_pkg::BS_IDLE) ? ddrbs_pkg::BS_IDLE
                                                             : ddrbs_pkg::BS_PRECHARGING;
                  cnt_q   <= timing.t_rp;
               end
            end
            default: begin
            end
         endcase
      end else begin
         if (!cnt_zero) begin
            cnt_q <= cnt_q - ddrbs_pkg::CNT_ONE;
         end
         if (done) begin
            case (state_q)
               ddrbs_pkg::BS_ACTIVATING:  state_q <= ddrbs_pkg::BS_ACTIVE;
               ddrbs_pkg::BS_READ:        state_q <= ddrbs_pkg::BS_ACTIVE;
               ddrbs_pkg::BS_READ_AP: begin
                  state_q <= ddrbs_pkg::BS_PRECHARGING;
                  cnt_q   <= timing.t_rp;
               end
               ddrbs_pkg::BS_WRITE: begin
                  state_q <= ddrbs_pkg::BS_WRREC;
                  cnt_q   <= timing.t_wr;
               end
               ddrbs_pkg::BS_WRITE_AP: begin
                  state_q <= ddrbs_pkg::BS_WRREC_AP;
                  cnt_q   <= timing.t_wr;
               end
               ddrbs_pkg::BS_WRREC:       state_q <= ddrbs_pkg::BS_ACTIVE;
               ddrbs_pkg::BS_WRREC_AP: begin
                  state_q <= ddrbs_pkg::BS_PRECHARGING;
                  cnt_q   <= timing.t_rp;
               end
               ddrbs_pkg::BS_PRECHARGING: state_q <= ddrbs_pkg::BS_IDLE;
               ddrbs_pkg::BS_REFRESHING:  state_q <= ddrbs_pkg::BS_IDLE;
               ddrbs_pkg::BS_MRS:         state_q <= ddrbs_pkg::BS_IDLE;
               default: begin
               end
            endcase
         end
      end
   end
endmodule

/* File: hw/ddrbs_top.sv */
/*
 ddr2 bank state and command legality tracker: decodes the command pins,
 keeps eight bank state machines and flags illegal commands.
 assumes pins are synchronous to clk and timing inputs are held steady.
*/
// Contract
// - during a burst with auto-precharge only deselect or nop is legal to that bank.
// - while precharging, deselect, nop or precharge act as nop and the bank idles after tRP.
// - while activating only deselect or nop is legal and the bank goes active after tRCD.
// - in write recovery a new write is legal and deselect or nop return to active after tWR.
// - in write recovery with auto-precharge only deselect or nop, precharging after tWR.
// - while refreshing only deselect or nop, returning to idle after tRC.
// - after a mode register set only deselect or nop, returning to idle after tMRD.
// - don't-care inputs do not change how a command decodes.
`timescale 1ns/1ps
module ddrbs_top (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // command pins
   input  ddrbs_pkg::ddrbs_pins_s       pins,
   // configuration
   input  ddrbs_pkg::ddrbs_timing_s     timing,
   input  wire logic                    burst_len8,
   // status
   output logic                         violation_q,
   output ddrbs_pkg::ddrbs_cmd_e        last_cmd_q,
   output logic [ddrbs_pkg::NUM_BANKS-1:0] bank_idle_q,
   output logic [ddrbs_pkg::NUM_BANKS-1:0] bank_active_q
);
   // pins only; address bits other than auto-precharge never enter decode
   function automatic ddrbs_pkg::ddrbs_cmd_e decode(input ddrbs_pkg::ddrbs_pins_s p);
      if (p.cs_n) begin
         decode = ddrbs_pkg::CMD_DESEL;
      end else begin
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h7:    decode = ddrbs_pkg::CMD_NOP;
            3'h5:    decode = ddrbs_pkg::CMD_READ;
            3'h4:    decode = ddrbs_pkg::CMD_WRITE;
            3'h3:    decode = ddrbs_pkg::CMD_ACT;
            3'h2:    decode = ddrbs_pkg::CMD_PRE;
            3'h1:    decode = ddrbs_pkg::CMD_REF;
            default: decode = ddrbs_pkg::CMD_MRS;
         endcase
      end
   endfunction

   ddrbs_pkg::ddrbs_cmd_e   cmd;
   logic                    auto_pre;
   logic                    all_idle;
   logic                    legal;
   logic                    all_cmd;
   logic                    pre_all;
   ddrbs_pkg::ddrbs_state_e st     [ddrbs_pkg::NUM_BANKS];
   logic                    czero  [ddrbs_pkg::NUM_BANKS];
   ddrbs_pkg::ddrbs_state_e tgt;
   logic                    tgt_boundary;
   logic [ddrbs_pkg::BEAT_W-1:0] beat_q [ddrbs_pkg::NUM_BANKS];
   logic                    col_ok;
   ddrbs_pkg::ddrbs_cnt_t   burst_cycles;

   assign cmd      = decode(pins);
   assign auto_pre = pins.addr[ddrbs_pkg::AP_BIT];
   assign pre_all  = (cmd == ddrbs_pkg::CMD_PRE) && auto_pre;
   assign all_cmd  = (cmd == ddrbs_pkg::CMD_REF) || (cmd == ddrbs_pkg::CMD_MRS);
   assign tgt      = st[pins.ba];
   // a burst of n beats takes n/2 clocks at double data rate
   assign burst_cycles = burst_len8
      ? ddrbs_pkg::ddrbs_cnt_t'(ddrbs_pkg::BURST_BL8 / ddrbs_pkg::DATA_RATE)
      : ddrbs_pkg::ddrbs_cnt_t'(ddrbs_pkg::BURST_BL4 / ddrbs_pkg::DATA_RATE);
   // at bl8 the 4-bit boundary falls after two clocks of the burst
   assign tgt_boundary = (czero[pins.ba] == 1'b0) &&
      (beat_q[pins.ba] == ddrbs_pkg::BEAT_W'(ddrbs_pkg::BURST_BL4 / ddrbs_pkg::DATA_RATE));

   always_comb begin
      all_idle = 1'b1;
      for (int i = 0; i < ddrbs_pkg::NUM_BANKS; i++) begin
         if (st[i] != ddrbs_pkg::BS_IDLE) begin
            all_idle = 1'b0;
         end
      end
   end

   // legality uses only the addressed bank, so other banks stay usable; refresh, mode set and precharge-all check every bank
   always_comb begin
      legal = 1'b1;
      case (cmd)
         ddrbs_pkg::CMD_DESEL, ddrbs_pkg::CMD_NOP: legal = 1'b1;
         ddrbs_pkg::CMD_REF, ddrbs_pkg::CMD_MRS:   legal = all_idle;
         ddrbs_pkg::CMD_ACT:   legal = (tgt == ddrbs_pkg::BS_IDLE);
         ddrbs_pkg::CMD_PRE: begin
            if (pre_all) begin
               legal = 1'b1;
               for (int i = 0; i < ddrbs_pkg::NUM_BANKS; i++) begin
                  if (!(st[i] inside {ddrbs_pkg::BS_IDLE, ddrbs_pkg::BS_ACTIVE,
                                      ddrbs_pkg::BS_PRECHARGING})) begin
                     legal = 1'b0;
                  end
               end
            end else begin
               legal = tgt inside {ddrbs_pkg::BS_IDLE, ddrbs_pkg::BS_ACTIVE,
                                   ddrbs_pkg::BS_PRECHARGING};
            end
         end
         ddrbs_pkg::CMD_READ:
            legal = (tgt == ddrbs_pkg::BS_ACTIVE) ||
                    ((tgt == ddrbs_pkg::BS_READ) && burst_len8 && tgt_boundary);
         ddrbs_pkg::CMD_WRITE:
            legal = (tgt == ddrbs_pkg::BS_ACTIVE) || (tgt == ddrbs_pkg::BS_WRREC) ||
                    ((tgt == ddrbs_pkg::BS_WRITE) && burst_len8 && tgt_boundary);
         default: legal = 1'b0;
      endcase
   end

   // clocks since the last accepted column command, per bank; a refused command or a
   // burst to another bank must not shift this bank's interrupt boundary
   assign col_ok = legal && ((cmd == ddrbs_pkg::CMD_READ) || (cmd == ddrbs_pkg::CMD_WRITE));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ddrbs_pkg::NUM_BANKS; i++) begin
            beat_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < ddrbs_pkg::NUM_BANKS; i++) begin
            if (col_ok && (pins.ba == ddrbs_pkg::BA_W'(i))) begin
               beat_q[i] <= ddrbs_pkg::BEAT_W'(1);
            end else if (beat_q[i] != '1) begin
               beat_q[i] <= beat_q[i] + ddrbs_pkg::BEAT_W'(1);
            end
         end
      end
   end

   for (genvar b = 0; b < ddrbs_pkg::NUM_BANKS; b++) begin : g_bank
      ddrbs_bank u_bank (
         .clk          (clk),
         .rst          (rst),
         .cmd_hit      ((pins.ba == ddrbs_pkg::BA_W'(b)) || pre_all),
         .cmd          (cmd),
         .auto_pre     (auto_pre),
         .cmd_legal    (legal),
         .all_cmd      (all_cmd),
         .timing       (timing),
         .burst_cycles (burst_cycles),
         .state        (st[b]),
         .cnt_zero     (czero[b])
      );
   end

   // status registered so every output comes from a flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         violation_q <= 1'b0;
         last_cmd_q  <= ddrbs_pkg::CMD_DESEL;
      end else begin
         violation_q <= !legal;
         last_cmd_q  <= cmd;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bank_idle_q   <= '1;
         bank_active_q <= '0;
      end else begin
         for (int i = 0; i < ddrbs_pkg::NUM_BANKS; i++) begin
            bank_idle_q[i]   <= (st[i] == ddrbs_pkg::BS_IDLE);
            bank_active_q[i] <= (st[i] == ddrbs_pkg::BS_ACTIVE);
         end
      end
   end
endmodule

/* File: dv/ddrbs_ctrl_model.sv */
/*
 behavioural memory controller: turns a requested command into pin levels.
 assumes the bench changes the request at the falling edge of clk.
*/
`timescale 1ns/1ps
module ddrbs_ctrl_model (
   // clock
   input  wire logic              clk,
   // request from the bench
   input  ddrbs_pkg::ddrbs_cmd_e  cmd,
   input  wire logic [2:0]        ba,
   input  wire logic              ap,
   // command pins
   output ddrbs_pkg::ddrbs_pins_s pins
);
   localparam logic [2:0] ENC [8] = '{3'h7, 3'h7, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
   int seed = 43;
   // fresh random levels on every don't-care pin, so decode cannot lean on stale values
   always @(negedge clk) begin
      #1;
      pins = 21'($random(seed));
      pins.cs_n = (cmd == ddrbs_pkg::CMD_DESEL);
      if (!pins.cs_n) begin
         {pins.ras_n, pins.cas_n, pins.we_n} = ENC[cmd];
      end
      if (cmd inside {ddrbs_pkg::CMD_READ, ddrbs_pkg::CMD_WRITE, ddrbs_pkg::CMD_ACT,
                      ddrbs_pkg::CMD_PRE}) begin
         pins.ba = ba;
         pins.addr[10] = ap;
      end
   end
endmodule

/* File: dv/ddrbs_checker.sv */
/*
 port-level checks of the bank state tracker, bound into ddrbs_top.
 assumes one clock and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
module ddrbs_checker (
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst,
   // tracker inputs
   input  ddrbs_pkg::ddrbs_pins_s               pins,
   input  ddrbs_pkg::ddrbs_timing_s             timing,
   input  wire logic                            burst_len8,
   // tracker outputs
   input  wire logic                            violation_q,
   input  ddrbs_pkg::ddrbs_cmd_e                last_cmd_q,
   input  wire logic [ddrbs_pkg::NUM_BANKS-1:0] bank_idle_q,
   input  wire logic [ddrbs_pkg::NUM_BANKS-1:0] bank_active_q
);
   ddrbs_pkg::ddrbs_cmd_e c;
   always_comb begin
      case ({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n})
         4'h7:    c = ddrbs_pkg::CMD_NOP;
         4'h5:    c = ddrbs_pkg::CMD_READ;
         4'h4:    c = ddrbs_pkg::CMD_WRITE;
         4'h3:    c = ddrbs_pkg::CMD_ACT;
         4'h2:    c = ddrbs_pkg::CMD_PRE;
         4'h1:    c = ddrbs_pkg::CMD_REF;
         4'h0:    c = ddrbs_pkg::CMD_MRS;
         default: c = ddrbs_pkg::CMD_DESEL;
      endcase
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a lagging status bit is only trusted where no command can undo it in one cycle
   property busy_then_idle(logic trig, ddrbs_pkg::ddrbs_cnt_t t);
      trig && t >= 8'h02 ##1 !violation_q |-> ##1 bank_idle_q == '0 ##[1:260] bank_idle_q == '1;
   endproperty
   property act_to_active;
      logic [ddrbs_pkg::BA_W-1:0] b;
      (c == ddrbs_pkg::CMD_ACT && timing.t_rcd >= 8'h02, b = pins.ba) ##1 !violation_q
         |-> ##1 !bank_active_q[b] ##[1:260] bank_active_q[b];
   endproperty
   property col_gap(int gap, logic intr, logic exp);
      logic [ddrbs_pkg::BA_W-1:0] b;
      (c == ddrbs_pkg::CMD_READ && !pins.addr[10], b = pins.ba) ##1 !violation_q ##(gap-1)
         intr && pins.ba == b |=> violation_q == exp;
   endproperty
   AST_DECODE: assert property (pins.cs_n || {pins.ras_n, pins.cas_n, pins.we_n} != 3'h6
      |=> last_cmd_q == $past(c)) else $error("decoded command mismatch");
   AST_NOOP_LEGAL: assert property (pins.cs_n || c == ddrbs_pkg::CMD_NOP
      |=> !violation_q) else $error("deselect or nop flagged");
   AST_ACT_ON_ACTIVE: assert property (c == ddrbs_pkg::CMD_ACT && bank_active_q[pins.ba]
      |=> violation_q) else $error("activate on active bank not flagged");
   AST_COL_ON_IDLE: assert property (c inside {ddrbs_pkg::CMD_READ, ddrbs_pkg::CMD_WRITE}
      && bank_idle_q[pins.ba] |=> violation_q) else $error("column on idle bank not flagged");
   AST_ALL_IDLE: assert property (c inside {ddrbs_pkg::CMD_REF, ddrbs_pkg::CMD_MRS}
      && bank_active_q != '0 |=> violation_q) else $error("refresh or mode set not flagged");
   AST_ACT_TO_ACTIVE: assert property (act_to_active) else $error("activate timing wrong");
   AST_REF_CYCLE: assert property (busy_then_idle(c == ddrbs_pkg::CMD_REF, timing.t_rc))
      else $error("refresh cycle wrong");
   AST_MRS_CYCLE: assert property (busy_then_idle(c == ddrbs_pkg::CMD_MRS, timing.t_mrd))
      else $error("mode set cycle wrong");
   AST_MID_BURST: assert property (col_gap(1, c == ddrbs_pkg::CMD_READ, 1'b1))
      else $error("read off burst boundary not flagged");
   AST_BL8_INTR: assert property (col_gap(2, c == ddrbs_pkg::CMD_READ && burst_len8, 1'b0))
      else $error("read interrupt refused");
   cover property (violation_q);
   cover property (c == ddrbs_pkg::CMD_REF);
   cover property (c == ddrbs_pkg::CMD_WRITE && burst_len8);
endmodule
bind ddrbs_top ddrbs_checker ddrbs_checker_inst (.clk(clk), .rst(rst), .pins(pins),
   .timing(timing), .burst_len8(burst_len8), .violation_q(violation_q),
   .last_cmd_q(last_cmd_q), .bank_idle_q(bank_idle_q), .bank_active_q(bank_active_q));

/* File: dv/test_ddrbs_top.sv */
/*
 self-checking bench for the bank state tracker.
 assumes the controller model drives the pins and the default timings.
*/
`timescale 1ns/1ps
module test_ddrbs_top;
   logic                     clk;
   logic                     rst;
   logic                     burst_len8;
   logic                     violation_q;
   logic                     req_ap;
   logic [2:0]               req_ba;
   logic [7:0]               bank_idle_q;
   logic [7:0]               bank_active_q;
   ddrbs_pkg::ddrbs_cmd_e    req;
   ddrbs_pkg::ddrbs_cmd_e    last_cmd_q;
   ddrbs_pkg::ddrbs_pins_s   pins;
   ddrbs_pkg::ddrbs_timing_s timing;
   logic [3:0]               notes[$];
   int                       bad_count;
   int                       num_checks;
   ddrbs_top ddrbs_top_inst (.clk(clk), .rst(rst), .pins(pins), .timing(timing),
      .burst_len8(burst_len8), .violation_q(violation_q), .last_cmd_q(last_cmd_q),
      .bank_idle_q(bank_idle_q), .bank_active_q(bank_active_q));
   ddrbs_ctrl_model ddrbs_ctrl_model_inst (.clk(clk), .cmd(req), .ba(req_ba), .ap(req_ap),
      .pins(pins));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // codes: 0 desel, 1 nop, 2 read, 3 write, 4 act, 5 pre, 6 ref, 7 mrs
   task automatic issue(logic [2:0] c, logic [2:0] b, logic ap, logic v);
      @(negedge clk);
      req = ddrbs_pkg::ddrbs_cmd_e'(c);
      req_ba = b;
      req_ap = ap;
      notes.push_back({v, c});
   endtask
   task automatic nops(int k);
      repeat (k) issue(3'h1, 3'h0, 1'b0, 1'b0);
   endtask
   task automatic wait_idle;
      int i;
      // the idle flags lag the last command by two edges
      nops(2);
      for (i = 0; i < 40 && bank_idle_q !== 8'hff; i++) nops(1);
      if (i == 40) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   // the result of an edge is read once that edge's updates have landed
   always @(posedge clk) begin
      #1;
      if (notes.size() > 0) begin
         chk("viol cmd", 8'(notes.pop_front()), {violation_q, last_cmd_q});
      end
   end
   initial begin
      #400000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      burst_len8 = 1'b0;
      req = ddrbs_pkg::CMD_DESEL;
      req_ba = 3'h0;
      req_ap = 1'b0;
      timing = {ddrbs_pkg::T_RP_DEF, ddrbs_pkg::T_RCD_DEF, ddrbs_pkg::T_WR_DEF,
                ddrbs_pkg::T_RC_DEF, ddrbs_pkg::T_MRD_DEF};
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk("bank_idle_q", 8'hff, bank_idle_q);
      for (int k = 0; k < 6; k++) issue(3'(k), 3'h0, 1'b0, 1'(k >= 2 && k != 4));
      nops(1);
      issue(3'h5, 3'h0, 1'b0, 1'b0);
      wait_idle();
      issue(3'h7, 3'h0, 1'b0, 1'b0);
      issue(3'h4, 3'h0, 1'b0, 1'b1);
      wait_idle();
      issue(3'h6, 3'h0, 1'b0, 1'b0);
      issue(3'h4, 3'h0, 1'b0, 1'b1);
      issue(3'h6, 3'h0, 1'b0, 1'b1);
      wait_idle();
      issue(3'h4, 3'h1, 1'b0, 1'b0);
      issue(3'h2, 3'h1, 1'b0, 1'b1);
      nops(1);
      issue(3'h2, 3'h1, 1'b1, 1'b0);
      issue(3'h5, 3'h1, 1'b0, 1'b1);
      issue(3'h4, 3'h2, 1'b0, 1'b0);
      issue(3'h7, 3'h0, 1'b0, 1'b1);
      nops(2);
      issue(3'h5, 3'h2, 1'b0, 1'b0);
      issue(3'h5, 3'h2, 1'b0, 1'b0);
      issue(3'h2, 3'h2, 1'b0, 1'b1);
      wait_idle();
      issue(3'h4, 3'h3, 1'b0, 1'b0);
      nops(2);
      issue(3'h3, 3'h3, 1'b0, 1'b0);
      nops(2);
      issue(3'h2, 3'h3, 1'b0, 1'b1);
      issue(3'h3, 3'h3, 1'b0, 1'b0);
      nops(6);
      chk("bank_active_q", 8'h08, bank_active_q);
      issue(3'h3, 3'h3, 1'b1, 1'b0);
      nops(2);
      issue(3'h3, 3'h3, 1'b0, 1'b1);
      wait_idle();
      burst_len8 = 1'b1;
      issue(3'h4, 3'h4, 1'b0, 1'b0);
      nops(2);
      issue(3'h2, 3'h4, 1'b0, 1'b0);
      issue(3'h2, 3'h4, 1'b0, 1'b1);
      issue(3'h2, 3'h4, 1'b0, 1'b0);
      nops(1);
      issue(3'h3, 3'h4, 1'b0, 1'b1);
      issue(3'h2, 3'h4, 1'b0, 1'b1);
      nops(4);
      issue(3'h5, 3'h4, 1'b0, 1'b0);
      wait_idle();
      report_and_stop();
   end
endmodule
